/* src/pfm_regs.svh */
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PFM_CTRL_OFS 8'h00
`define PFM_LIMIT_OFS 8'h04
`define PFM_LOWSET_OFS 8'h08
`define PFM_HIGHSET_OFS 8'h0C
`define PFM_DELAY_OFS 8'h10
`define PFM_STATUS_OFS 8'h14
`define PFM_EVENT_OFS 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFM_RUN_BIT 0
`define PFM_MIN_LSB 0
`define PFM_MAX_LSB 8
`define PFM_DLY1_LSB 0
`define PFM_DLY2_LSB 8
`define PFM_FAULT_BIT 8
`define PFM_HS_LSB 9
`define PFM_TRIG_BIT 11
`define PFM_ERRFLAG_BIT 0

// ----------------------------------------
// Reset values and tally ceiling
// ----------------------------------------
`define PFM_LIMIT_RST 4'h0
`define PFM_SET_RST 8'h00
`define PFM_TALLY_MAX 5'h1F

// ----------------------------------------
// Timing
// ----------------------------------------
`define PFM_CLK_MHZ 25
`define PFM_TICK_US 15
`define PFM_TICK_CYCLES (`PFM_TICK_US * `PFM_CLK_MHZ)
`define PFM_DELAY_UNIT_US 2048
`define PFM_DELAY_UNIT_CYCLES (`PFM_DELAY_UNIT_US * `PFM_CLK_MHZ)

`endif

/* src/pfm_pkg.sv */
package pfm_pkg;

  // Error-handling procedure steps
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_DELAY1,
    HS_DELAY2,
    HS_TRIGGER
  } pfm_handle_type;

  // Input front-end state
  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic rise;
    logic fall;
    logic [8:0] tickCnt;
    logic tick;
  } pfm_front_type;

  // Counter and bus state
  typedef struct packed {
    logic run;
    logic [3:0] limit;
    logic [7:0] lmin;
    logic [7:0] lmax;
    logic [7:0] hmin;
    logic [7:0] hmax;
    logic [7:0] dly1;
    logic [7:0] dly2;
    logic [4:0] tally;
    logic errFlag;
    pfm_handle_type hs;
    logic [7:0] dlyCnt;
    logic [15:0] unitCnt;
    logic trig;
    logic [8:0] durCnt;
    logic startPulse;
    logic overran;
    logic prevGood;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } pfm_state_type;

endpackage : pfm_pkg

/* src/pfm_pulse_if.sv */
`timescale 1ns/1ns
interface pfm_pulse_if;
  logic level;
  logic rise;
  logic fall;
  logic tick;
  modport src (output level, rise, fall, tick);
  modport dst (input level, rise, fall, tick);
endinterface : pfm_pulse_if

/* src/pfm_pulse_front.sv */
`timescale 1ns/1ns
`include "pfm_regs.svh"
module pfm_pulse_front
  import pfm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic processorErrorInput,
  pfm_pulse_if.src pulse
);

  pfm_front_type st_q;
  pfm_front_type st_d;

  // ----------------------------------------
  // Sync, edge detect, 15 us tick
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[1:0], processorErrorInput};
    st_d.rise = 1'b0;
    st_d.fall = 1'b0;
    // Level moves once stages two and three agree
    if (st_q.sync[2] == st_q.sync[1] && st_q.sync[2] != st_q.level) begin
      st_d.level = st_q.sync[2];
      st_d.rise = st_q.sync[2];
      st_d.fall = ~st_q.sync[2];
    end
    st_d.tick = 1'b0;
    if (st_q.tickCnt == 9'(`PFM_TICK_CYCLES - 1)) begin
      st_d.tickCnt = 9'h000;
      st_d.tick = 1'b1;
    end else begin
      st_d.tickCnt = st_q.tickCnt + 9'h001;
    end
  end

  // State register, input idles high
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{sync: 3'h7, level: 1'b1, rise: 1'b0, fall: 1'b0, tickCnt: 9'h000, tick: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse.level = st_q.level;
  assign pulse.rise = st_q.rise;
  assign pulse.fall = st_q.fall;
  assign pulse.tick = st_q.tick;

endmodule : pfm_pulse_front

/* src/pfm_error_counter.sv */
`timescale 1ns/1ns
`include "pfm_regs.svh"
// How it works
// - Bad event adds two to tally
// - Good event takes one from tally
// - Tally held zero while not running
// - Limit writable only while stopped
// - Tally above limit starts error handling
// - Handling stops: tally low, flags cleared
// - Both delays elapse: trigger, clear run
// - Sequencer done reinitialises the monitor
// - Low start: timer from low maximum
// - Early rise enters high-pulse monitoring
// - Start timer expiry is a bad event
// - High start: timer from high maximum
// - Early fall enters low-pulse monitoring
// - Events keep counting during handling
// - Pulse outside min/max window is bad
// - Two in-window pulses make good event
// - Threshold is 15 us times setting+1
// - Overlong level repeats bad events
module pfm_error_counter
  import pfm_pkg::*;
#(
  parameter int DelayUnitCycles = `PFM_DELAY_UNIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic processorErrorInput,
  input wire logic powerSequenceFsmDone,
  output logic monitorResetTrigger
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Pulse threshold in 15 us ticks
  function automatic logic [8:0] thrTicks(input logic [7:0] setting);
    thrTicks = {1'b0, setting} + 9'h001;
  endfunction : thrTicks

  // Saturating tally update
  function automatic logic [4:0] tallyStep(input logic [4:0] t, input logic bad, input logic good);
    logic [5:0] sum;
    sum = {1'b0, t} + 6'h02;
    tallyStep = t;
    if (bad) begin
      tallyStep = sum[5] ? `PFM_TALLY_MAX : sum[4:0];
    end else if (good && t != 5'h00) begin
      tallyStep = t - 5'h01;
    end
  endfunction : tallyStep

  pfm_pulse_if pulse ();

  pfm_pulse_front u_front (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .processorErrorInput(processorErrorInput),
    .pulse(pulse)
  );

  pfm_state_type st_q;
  pfm_state_type st_d;
  logic badEvt;
  logic goodEvt;
  logic wrEn;
  logic rdEn;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic edgeSeen;
    logic inWin;
    logic [7:0] minSel;
    logic [7:0] maxSel;
    logic [7:0] dlySel;
    logic hit;
    logic [31:0] rd;
    edgeSeen = pulse.rise | pulse.fall;
    inWin = 1'b0;
    minSel = pulse.rise ? st_q.lmin : st_q.hmin;
    maxSel = pulse.level ? st_q.hmax : st_q.lmax;
    dlySel = (st_q.hs == HS_DELAY2) ? st_q.dly2 : st_q.dly1;
    hit = 1'b0;
    rd = 32'h0000_0000;
    badEvt = 1'b0;
    goodEvt = 1'b0;
    st_d = st_q;

    // Bus handshake, one wait cycle
    wrEn = psel & penable & st_q.ready & pwrite;
    rdEn = psel & penable & ~st_q.ready;
    st_d.ready = rdEn;
    st_d.slverr = 1'b0;

    // Pulse classification
    if (!st_q.run) begin
      // Stopped: arm the start-up measurement
      st_d.durCnt = 9'h000;
      st_d.startPulse = 1'b1;
      st_d.overran = 1'b0;
      st_d.prevGood = 1'b0;
    end else if (edgeSeen) begin
      if (st_q.startPulse) begin
        // First edge in time: start normal monitoring
        st_d.prevGood = 1'b0;
      end else begin
        inWin = ~st_q.overran && st_q.durCnt >= thrTicks(minSel);
        badEvt = ~st_q.overran && ~inWin;
        goodEvt = inWin && st_q.prevGood;
        st_d.prevGood = inWin;
      end
      st_d.durCnt = 9'h000;
      st_d.startPulse = 1'b0;
      st_d.overran = 1'b0;
    end else if (pulse.tick) begin
      if (st_q.durCnt >= thrTicks(maxSel)) begin
        // Too long, also covers start-up timeout
        badEvt = 1'b1;
        st_d.durCnt = 9'h000;
        st_d.overran = 1'b1;
        st_d.startPulse = 1'b0;
        st_d.prevGood = 1'b0;
      end else begin
        st_d.durCnt = st_q.durCnt + 9'h001;
      end
    end

    // Tally, counted in idle and both delay steps; held zero in trigger step as run is clear
    st_d.tally = tallyStep(st_q.tally, badEvt, goodEvt);

    // Event flag, set wins over clear
    if (wrEn && paddr == `PFM_EVENT_OFS && pwdata[`PFM_ERRFLAG_BIT]) begin
      st_d.errFlag = 1'b0;
    end
    if (st_q.run && st_q.tally > {1'b0, st_q.limit}) begin
      st_d.errFlag = 1'b1;
    end

    // Delay unit prescaler
    if (st_q.unitCnt == 16'(DelayUnitCycles - 1)) begin
      st_d.unitCnt = 16'h0000;
      hit = 1'b1;
    end else begin
      st_d.unitCnt = st_q.unitCnt + 16'h0001;
    end

    // Error-handling procedure
    case (st_q.hs)
      HS_IDLE: begin
        if (st_q.run && st_q.tally > {1'b0, st_q.limit}) begin
          st_d.hs = HS_DELAY1;
          st_d.dlyCnt = 8'h00;
          st_d.unitCnt = 16'h0000;
        end
      end
      HS_DELAY1, HS_DELAY2: begin
        if (!st_q.run) begin
          st_d.hs = HS_IDLE;
        end else if (st_q.tally <= {1'b0, st_q.limit} && !st_q.errFlag) begin
          st_d.hs = HS_IDLE;
        end else if (st_q.dlyCnt == dlySel) begin
          st_d.dlyCnt = 8'h00;
          st_d.unitCnt = 16'h0000;
          if (st_q.hs == HS_DELAY1 && st_q.dly2 != 8'h00) begin
            st_d.hs = HS_DELAY2;
          end else begin
            st_d.hs = HS_TRIGGER;
            st_d.trig = 1'b1;
          end
        end else if (hit) begin
          st_d.dlyCnt = st_q.dlyCnt + 8'h01;
        end
      end
      HS_TRIGGER: begin
        if (powerSequenceFsmDone) begin
          st_d.trig = 1'b0;
          st_d.errFlag = 1'b0;
          st_d.hs = HS_IDLE;
        end
      end
      default: begin
        st_d.hs = HS_IDLE;
      end
    endcase

    // Register writes
    if (wrEn) begin
      case (paddr)
        `PFM_CTRL_OFS: begin
          if (st_q.hs != HS_TRIGGER) begin
            st_d.run = pwdata[`PFM_RUN_BIT];
          end
        end
        `PFM_LIMIT_OFS: begin
          if (!st_q.run) begin
            st_d.limit = pwdata[3:0];
          end
        end
        `PFM_LOWSET_OFS: begin
          st_d.lmin = pwdata[`PFM_MIN_LSB +: 8];
          st_d.lmax = pwdata[`PFM_MAX_LSB +: 8];
        end
        `PFM_HIGHSET_OFS: begin
          st_d.hmin = pwdata[`PFM_MIN_LSB +: 8];
          st_d.hmax = pwdata[`PFM_MAX_LSB +: 8];
        end
        `PFM_DELAY_OFS: begin
          st_d.dly1 = pwdata[`PFM_DLY1_LSB +: 8];
          st_d.dly2 = pwdata[`PFM_DLY2_LSB +: 8];
        end
        default: begin
        end
      endcase
    end

    // Trigger issue clears run
    if (st_d.trig && !st_q.trig) begin
      st_d.run = 1'b0;
    end
    if (!st_d.run) begin
      st_d.tally = 5'h00;
    end

    // Read data and unmapped answer
    case (paddr)
      `PFM_CTRL_OFS: rd[`PFM_RUN_BIT] = st_q.run;
      `PFM_LIMIT_OFS: rd[3:0] = st_q.limit;
      `PFM_LOWSET_OFS: rd[15:0] = {st_q.lmax, st_q.lmin};
      `PFM_HIGHSET_OFS: rd[15:0] = {st_q.hmax, st_q.hmin};
      `PFM_DELAY_OFS: rd[15:0] = {st_q.dly2, st_q.dly1};
      `PFM_STATUS_OFS: begin
        rd[4:0] = st_q.tally;
        rd[`PFM_FAULT_BIT] = st_q.tally > {1'b0, st_q.limit};
        rd[`PFM_HS_LSB +: 2] = st_q.hs;
        rd[`PFM_TRIG_BIT] = st_q.trig;
      end
      `PFM_EVENT_OFS: rd[`PFM_ERRFLAG_BIT] = st_q.errFlag;
      default: st_d.slverr = rdEn;
    endcase
    if (rdEn) begin
      st_d.rdata = rd;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{
        run: 1'b0, limit: `PFM_LIMIT_RST,
        lmin: `PFM_SET_RST, lmax: `PFM_SET_RST,
        hmin: `PFM_SET_RST, hmax: `PFM_SET_RST,
        dly1: `PFM_SET_RST, dly2: `PFM_SET_RST,
        tally: 5'h00, errFlag: 1'b0, hs: HS_IDLE,
        dlyCnt: 8'h00, unitCnt: 16'h0000, trig: 1'b0,
        durCnt: 9'h000, startPulse: 1'b1, overran: 1'b0,
        prevGood: 1'b0, ready: 1'b0, slverr: 1'b0,
        rdata: 32'h0000_0000
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.slverr;
  assign monitorResetTrigger = st_q.trig;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_bad_adds_two: assert property (
    st_q.run && st_d.run && badEvt && st_q.tally <= 5'h1D |=> st_q.tally == $past(st_q.tally) + 5'h02)
    else $error("bad event did not add two");

  a_good_minus_one: assert property (
    st_q.run && st_d.run && goodEvt && st_q.tally != 5'h00 |=> st_q.tally == $past(st_q.tally) - 5'h01)
    else $error("good event did not subtract one");

  a_stopped_tally_zero: assert property (!st_q.run |-> st_q.tally == 5'h00)
    else $error("tally nonzero while stopped");

  a_limit_locked: assert property (st_q.run && st_d.run |=> st_q.limit == $past(st_q.limit))
    else $error("limit changed while running");

  a_fault_starts: assert property (
    st_q.hs == HS_IDLE && st_q.run && st_q.tally > {1'b0, st_q.limit} |=> st_q.hs == HS_DELAY1)
    else $error("fault did not start handling");

  a_trigger_stops_run: assert property ($rose(st_q.trig) |-> !st_q.run && st_q.hs == HS_TRIGGER)
    else $error("trigger without run clear");

  a_reinit_done: assert property (
    st_q.hs == HS_TRIGGER && powerSequenceFsmDone |=> !st_q.trig && st_q.hs == HS_IDLE && !st_q.errFlag)
    else $error("monitor not reinitialised");

  a_tally_no_wrap: assert property (
    st_q.run && st_d.run && st_q.tally == `PFM_TALLY_MAX && badEvt |=> st_q.tally == `PFM_TALLY_MAX)
    else $error("tally wrapped");

  a_start_armed: assert property ($rose(st_q.run) |-> st_q.startPulse && st_q.durCnt == 9'h000)
    else $error("start-up timer not armed");

  a_early_edge_silent: assert property (
    st_q.run && st_q.startPulse && (pulse.rise || pulse.fall) |-> !badEvt && !goodEvt)
    else $error("start-up edge produced an event");

  a_overlong_bad: assert property (
    st_q.run && pulse.tick && !pulse.rise && !pulse.fall
    && st_q.durCnt >= thrTicks(pulse.level ? st_q.hmax : st_q.lmax) |-> badEvt ##1 st_q.durCnt == 9'h000)
    else $error("overlong pulse missed");

  c_good_event: cover property (st_q.run && goodEvt);
  c_handling_recovers: cover property (st_q.hs == HS_DELAY1 ##1 st_q.hs == HS_IDLE);
  c_trigger_issued: cover property ($rose(st_q.trig));

endmodule : pfm_error_counter

/* bench/pfm_pulse_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Processor pulse-train source
// ----------------------------------------
module pfm_pulse_model (
  input wire logic ref_clk,
  input wire logic enable,
  input wire logic [15:0] highCycles,
  input wire logic [15:0] lowCycles,
  output logic pinLevel
);
  logic [15:0] phaseCnt;

  initial begin
    pinLevel = 1'b1;
    phaseCnt = 16'hFFFF;
  end

  // Idle pulled high; an enabled train opens with its low phase
  always @(posedge ref_clk) begin
    if (!enable) begin
      pinLevel <= 1'b1;
      phaseCnt <= 16'hFFFF;
    end else if (phaseCnt >= (pinLevel ? highCycles : lowCycles)) begin
      pinLevel <= ~pinLevel;
      phaseCnt <= 16'h0001;
    end else begin
      phaseCnt <= phaseCnt + 16'h0001;
    end
  end
endmodule : pfm_pulse_model

/* bench/tb_top.sv */
`timescale 1ns/1ns
`include "pfm_regs.svh"
`define PFM_CHK(got, exp) begin checks++; if ((got) !== (exp)) begin nErrors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, rdErr;
  logic processorErrorInput, powerSequenceFsmDone, monitorResetTrigger, genEnable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [15:0] genHigh, genLow;
  int nErrors = 0;
  int checks = 0;
  int n;

  pfm_error_counter #(.DelayUnitCycles(16)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .processorErrorInput(processorErrorInput), .powerSequenceFsmDone(powerSequenceFsmDone),
    .monitorResetTrigger(monitorResetTrigger)
  );

  pfm_pulse_model i_gen (
    .ref_clk(ref_clk), .enable(genEnable), .highCycles(genHigh), .lowCycles(genLow),
    .pinLevel(processorErrorInput)
  );

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task give_verdict;
    $display("errors %0d checks %0d", nErrors, checks);
    if (nErrors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // One APB transfer, held until pready
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      nErrors++;
      $display("wrong value at %0t: bus timeout", $time);
      give_verdict();
    end
  endtask : apb

  task wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask : wr

  task rd(input logic [7:0] addr);
    apb(1'b0, addr, 32'h00000000);
  endtask : rd

  task idle(input int cnt);
    repeat (cnt) @(posedge ref_clk);
  endtask : idle

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    powerSequenceFsmDone = 1'b0;
    genEnable = 1'b0;
    genHigh = 16'd560;
    genLow = 16'd1125;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Reset state and unmapped access
    rd(`PFM_CTRL_OFS);
    `PFM_CHK(rdVal, 32'h00000000)
    rd(`PFM_STATUS_OFS);
    `PFM_CHK(rdVal, 32'h00000000)
    rd(8'h1C);
    `PFM_CHK(rdErr, 1'b1)
    // Limit while stopped, settings, then run with input high
    wr(`PFM_LIMIT_OFS, 32'h00000003);
    rd(`PFM_LIMIT_OFS);
    `PFM_CHK(rdVal, 32'h00000003)
    wr(`PFM_HIGHSET_OFS, 32'h00000200);
    wr(`PFM_LOWSET_OFS, 32'h00000400);
    wr(`PFM_DELAY_OFS, 32'h0000FFFF);
    wr(`PFM_CTRL_OFS, 32'h00000001);
    wr(`PFM_LIMIT_OFS, 32'h00000007);
    rd(`PFM_LIMIT_OFS);
    `PFM_CHK(rdVal, 32'h00000003)
    // Start timer expiry, then repeated overruns
    idle(1500);
    rd(`PFM_STATUS_OFS);
    `PFM_CHK(rdVal, 32'h00000002)
    idle(1500);
    rd(`PFM_STATUS_OFS);
    `PFM_CHK(rdVal, 32'h00000304)
    rd(`PFM_EVENT_OFS);
    `PFM_CHK(rdVal, 32'h00000001)
    // Good pulses during handling, then software recovery
    genEnable <= 1'b1;
    idle(2870);
    wr(`PFM_EVENT_OFS, 32'h00000001);
    rd(`PFM_STATUS_OFS);
    `PFM_CHK(rdVal, 32'h00000002)
    // Persistent fault runs out both delays
    genEnable <= 1'b0;
    n = 0;
    while (monitorResetTrigger !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    `PFM_CHK(monitorResetTrigger, 1'b1)
    if (monitorResetTrigger !== 1'b1) begin
      give_verdict();
    end
    rd(`PFM_CTRL_OFS);
    `PFM_CHK(rdVal, 32'h00000000)
    rd(`PFM_STATUS_OFS);
    `PFM_CHK(rdVal, 32'h00000E00)
    // Sequencer done reinitialises
    powerSequenceFsmDone <= 1'b1;
    @(posedge ref_clk);
    powerSequenceFsmDone <= 1'b0;
    idle(2);
    `PFM_CHK(monitorResetTrigger, 1'b0)
    rd(`PFM_EVENT_OFS);
    `PFM_CHK(rdVal, 32'h00000000)
    idle(2000);
    rd(`PFM_STATUS_OFS);
    `PFM_CHK(rdVal, 32'h00000000)
    // Low start, early rise, then a too-short high pulse
    wr(`PFM_HIGHSET_OFS, 32'h00000803);
    genEnable <= 1'b1;
    idle(8);
    wr(`PFM_CTRL_OFS, 32'h00000001);
    idle(2500);
    rd(`PFM_STATUS_OFS);
    `PFM_CHK(rdVal, 32'h00000002)
    give_verdict();
  end
endmodule : tb_top
